// [design/arct_timer.sv]
// Contract
// (R1) In 16-bit mode the count reloads from the reload value on wrap past 0xFFFF and sets the high flag.
// (R2) In 16-bit mode an enabled timer interrupt is requested on every 16-bit overflow.
// (R3) In 16-bit mode with low interrupts enabled, a low-byte wrap also requests an interrupt.
// (R4) In split mode both bytes are separate 8-bit timers, each reloading from its own reload byte.
// (R5) In split mode run control gates only the high byte; the low byte always counts.
// (R6) The high byte runs on the system clock or on the source picked by the external select.
// (R7) The low byte picks its clock the same way through its own clock-select bit.
// (R8) The divided oscillator and comparator inputs are synchronised before they count.
// (R9) In split mode each byte wrap sets its own overflow flag.
// (R10) In split mode a high wrap interrupts, and a low wrap too when low interrupts are enabled.
// (R11) Hardware never clears the overflow flags; software clears them and checks both.
// (R12) Capture enable puts the timer in capture mode using the full 16-bit count.
// (R13) In capture mode the upper select bit picks comparator edges or every 8 oscillator cycles.
// (R14) A capture copies the count into the reload registers and sets the high flag.
// (R15) The control register holds flags, enables, mode, run and select; all read/write, reset zero.
// (R16) The count advances one step per enable: every cycle on the system clock, else a divide-by-12 tick or a pulse built from a synchronised rising edge.
`timescale 1ns/10ps
`default_nettype none
module arct_timer #(
	parameter int PRESCALE_DIV = arct_pkg::SYSTEM_CLOCK_DIVIDE,
	parameter int EXT_DIV = arct_pkg::EXT_DIVIDE
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire arct_pkg::arct_axil_req_t axil_req,
	output arct_pkg::arct_axil_rsp_t axil_rsp,
	input wire logic ext_osc_in,
	input wire logic comparator_in,
	output logic timer_irq
);
	import arct_pkg::*;

	localparam int PW = $clog2(PRESCALE_DIV);
	localparam int EW = $clog2(EXT_DIV);
	localparam logic [PW-1:0] PRESCALE_LAST = PW'(PRESCALE_DIV - 1);
	localparam logic [EW-1:0] EXT_LAST = EW'(EXT_DIV - 1);

	function automatic logic src_tick(input logic sys_sel,
			input logic [1:0] xsel, input logic d12, input logic e8,
			input logic cmp);
		logic t;
		if (sys_sel) begin
			t = 1'b1;
		end else begin
			case (arct_src_t'(xsel))
				SRC_DIV12_A: t = d12;
				SRC_EXT_DIV8: t = e8;
				SRC_DIV12_B: t = d12;
				SRC_COMPARATOR: t = cmp;
				default: t = 1'b0;
			endcase
		end
		return t;
	endfunction

	function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
		return a == OFF_TIMER_CONTROL || a == OFF_COUNT_LOW ||
			a == OFF_COUNT_HIGH || a == OFF_RELOAD_LOW ||
			a == OFF_RELOAD_HIGH || a == OFF_CLOCK_CONTROL ||
			a == OFF_IRQ_ENABLE;
	endfunction

	logic [CFG_W-1:0] cfg;
	logic high_flag, low_flag;
	logic low_clk_sel, high_clk_sel, irq_en;
	logic [15:0] count, reload;
	logic [PW-1:0] presc;
	logic [EW-1:0] ext_cnt;
	logic div12_tick, ext8_tick, ext_rise, comp_rise;
	logic aw_held, w_held, awready, wready, bvalid, arready, rvalid;
	logic [ADDR_W-1:0] aw_addr;
	logic [7:0] w_byte;
	logic w_lane0;
	logic [1:0] bresp, rresp;
	logic [DATA_W-1:0] rdata;

	logic run, split, cap_en, low_irq_en;
	logic tick_lo, tick_hi, cap_event, do_write, wr_en;
	logic wr_ctrl, wr_cnt_lo, wr_cnt_hi, wr_rld_lo, wr_rld_hi;
	logic [15:0] next_count;
	logic lo_wrap, hi_wrap;
	logic aw_take, w_take, ar_take;

	assign run = cfg[BIT_RUN];
	assign split = cfg[BIT_SPLIT];
	assign cap_en = cfg[BIT_CAPTURE_EN];
	assign low_irq_en = cfg[BIT_LOW_IRQ_EN];

	assign axil_rsp = '{awready: awready, wready: wready, bvalid: bvalid,
		bresp: bresp, arready: arready, rvalid: rvalid, rdata: rdata,
		rresp: rresp};

	// slow sources become one-cycle enables on sys_clk
	arct_edge_sync u_ext_sync (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.async_in(ext_osc_in),
		.rise(ext_rise)
	); // see (R8)

	arct_edge_sync u_cmp_sync (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.async_in(comparator_in),
		.rise(comp_rise)
	); // see (R8)

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			presc <= '0;
			div12_tick <= 1'b0;
		end else begin
			presc <= (presc == PRESCALE_LAST) ? '0 : presc + 1'b1;
			div12_tick <= presc == PRESCALE_LAST;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_cnt <= '0;
			ext8_tick <= 1'b0;
		end else begin
			if (ext_rise) begin
				ext_cnt <= (ext_cnt == EXT_LAST) ? '0 : ext_cnt + 1'b1;
			end
			ext8_tick <= ext_rise && ext_cnt == EXT_LAST; // see (R16)
		end
	end

	assign tick_lo = src_tick(low_clk_sel, cfg[BIT_SEL_HI:BIT_SEL_LO],
		div12_tick, ext8_tick, comp_rise); // see (R7)
	assign tick_hi = src_tick(high_clk_sel, cfg[BIT_SEL_HI:BIT_SEL_LO],
		div12_tick, ext8_tick, comp_rise); // see (R6)
	assign cap_event = cap_en &&
		(cfg[BIT_SEL_HI] ? ext8_tick : comp_rise); // see (R13)

	always_comb begin
		next_count = count;
		lo_wrap = 1'b0;
		hi_wrap = 1'b0;
		if (cap_en) begin
			// free running 16-bit count; reload holds the capture
			if (run && tick_lo) begin
				next_count = count + 16'h0001; // see (R12)
				lo_wrap = count[7:0] == BYTE_TOP;
			end
		end else if (!split) begin
			if (run && tick_lo) begin
				lo_wrap = count[7:0] == BYTE_TOP; // see (R3)
				if (count == COUNT_TOP) begin
					next_count = reload; // see (R1)
					hi_wrap = 1'b1;
				end else begin
					next_count = count + 16'h0001; // see (R16)
				end
			end
		end else begin
			if (tick_lo) begin
				lo_wrap = count[7:0] == BYTE_TOP; // see (R5)
				next_count[7:0] = lo_wrap ? reload[7:0] :
					count[7:0] + 8'h01; // see (R4)
			end
			if (run && tick_hi) begin
				hi_wrap = count[15:8] == BYTE_TOP; // see (R9)
				next_count[15:8] = hi_wrap ? reload[15:8] :
					count[15:8] + 8'h01; // see (R4)
			end
		end
	end

	// register bus: write strobes
	assign aw_take = axil_req.awvalid && awready;
	assign w_take = axil_req.wvalid && wready;
	assign ar_take = axil_req.arvalid && arready;
	assign do_write = aw_held && w_held && !bvalid;
	// registers are one byte wide, so only lane 0 carries data
	assign wr_en = do_write && w_lane0 && addr_mapped(aw_addr);
	assign wr_ctrl = wr_en && aw_addr == OFF_TIMER_CONTROL;
	assign wr_cnt_lo = wr_en && aw_addr == OFF_COUNT_LOW;
	assign wr_cnt_hi = wr_en && aw_addr == OFF_COUNT_HIGH;
	assign wr_rld_lo = wr_en && aw_addr == OFF_RELOAD_LOW;
	assign wr_rld_hi = wr_en && aw_addr == OFF_RELOAD_HIGH;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_held <= 1'b0;
			awready <= 1'b0;
			aw_addr <= '0;
		end else begin
			if (aw_take) begin
				aw_addr <= axil_req.awaddr;
			end
			aw_held <= do_write ? 1'b0 : (aw_held | aw_take);
			awready <= do_write ? 1'b1 : !(aw_held | aw_take);
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			w_held <= 1'b0;
			wready <= 1'b0;
			w_byte <= 8'h00;
			w_lane0 <= 1'b0;
		end else begin
			if (w_take) begin
				w_byte <= axil_req.wdata[7:0];
				w_lane0 <= axil_req.wstrb[0];
			end
			w_held <= do_write ? 1'b0 : (w_held | w_take);
			wready <= do_write ? 1'b1 : !(w_held | w_take);
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else if (do_write) begin
			bvalid <= 1'b1;
			bresp <= addr_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
		end else if (axil_req.bready) begin
			bvalid <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OKAY;
		end else begin
			arready <= !(ar_take || (rvalid && !axil_req.rready));
			if (ar_take) begin
				rvalid <= 1'b1;
				rresp <= addr_mapped(axil_req.araddr) ? RESP_OKAY :
					RESP_SLVERR;
				case (axil_req.araddr)
					OFF_TIMER_CONTROL: rdata <= {24'h000000, high_flag,
						low_flag, cfg};
					OFF_COUNT_LOW: rdata <= {24'h000000, count[7:0]};
					OFF_COUNT_HIGH: rdata <= {24'h000000, count[15:8]};
					OFF_RELOAD_LOW: rdata <= {24'h000000, reload[7:0]};
					OFF_RELOAD_HIGH: rdata <= {24'h000000, reload[15:8]};
					OFF_CLOCK_CONTROL: rdata <= {30'h00000000,
						high_clk_sel, low_clk_sel};
					OFF_IRQ_ENABLE: rdata <= {31'h00000000, irq_en};
					default: rdata <= '0;
				endcase
			end else if (axil_req.rready) begin
				rvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg <= CFG_RESET;
		end else if (wr_ctrl) begin
			cfg <= w_byte[CFG_W-1:0]; // see (R15)
		end
	end

	// flag set beats a software clear in the same cycle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			high_flag <= 1'b0;
			low_flag <= 1'b0;
		end else begin
			high_flag <= (wr_ctrl ? w_byte[BIT_HIGH_FLAG] : high_flag) |
				hi_wrap | cap_event; // see (R11) see (R14)
			low_flag <= (wr_ctrl ? w_byte[BIT_LOW_FLAG] : low_flag) |
				lo_wrap; // see (R11)
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			low_clk_sel <= 1'b0;
			high_clk_sel <= 1'b0;
			irq_en <= 1'b0;
		end else begin
			if (wr_en && aw_addr == OFF_CLOCK_CONTROL) begin
				low_clk_sel <= w_byte[BIT_LOW_CLK_SEL];
				high_clk_sel <= w_byte[BIT_HIGH_CLK_SEL];
			end
			if (wr_en && aw_addr == OFF_IRQ_ENABLE) begin
				irq_en <= w_byte[BIT_TIMER_IRQ_EN];
			end
		end
	end

	// software write to a count byte overrides that cycle's step
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= COUNT_RESET;
		end else begin
			count[7:0] <= wr_cnt_lo ? w_byte : next_count[7:0];
			count[15:8] <= wr_cnt_hi ? w_byte : next_count[15:8];
		end
	end

	// a capture wins over a software reload write
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			reload <= RELOAD_RESET;
		end else if (cap_event) begin
			reload <= count; // see (R14)
		end else begin
			if (wr_rld_lo) begin
				reload[7:0] <= w_byte;
			end
			if (wr_rld_hi) begin
				reload[15:8] <= w_byte;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			timer_irq <= 1'b0;
		end else begin
			timer_irq <= irq_en &&
				(high_flag || (low_irq_en && low_flag)); // see (R2) see (R10)
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	chk_wide_reload: assert property ( // see (R1)
		!cap_en && !split && run && tick_lo && count == COUNT_TOP &&
		!wr_cnt_lo && !wr_cnt_hi |=> count == $past(reload) && high_flag)
		else $error("16-bit wrap did not reload or flag");
	chk_irq_high: assert property ( // see (R2)
		irq_en && high_flag |=> timer_irq)
		else $error("high flag did not raise the interrupt");
	chk_irq_low: assert property ( // see (R3)
		irq_en && low_irq_en && low_flag |=> timer_irq)
		else $error("low flag did not raise the interrupt");
	chk_split_low_reload: assert property ( // see (R4)
		split && !cap_en && tick_lo && count[7:0] == BYTE_TOP &&
		!wr_cnt_lo |=> count[7:0] == $past(reload[7:0]) && low_flag)
		else $error("low byte did not reload in split mode");
	chk_split_run_gate: assert property ( // see (R5)
		split && !cap_en && !run && !wr_cnt_hi |=>
		count[15:8] == $past(count[15:8]))
		else $error("high byte moved while stopped");
	chk_system_clock_select: assert property ( // see (R6)
		split && !cap_en && high_clk_sel && run && !wr_cnt_hi &&
		count[15:8] != BYTE_TOP |=>
		count[15:8] == $past(count[15:8]) + 8'h01)
		else $error("high byte not stepped on the system clock");
	chk_low_system_clock_step: assert property ( // see (R7)
		split && !cap_en && low_clk_sel && !wr_cnt_lo &&
		count[7:0] != BYTE_TOP |=>
		count[7:0] == $past(count[7:0]) + 8'h01)
		else $error("low byte not stepped on the system clock");
	chk_sync_pulse: assert property ( // see (R8)
		comp_rise |=> !comp_rise)
		else $error("comparator enable longer than one cycle");
	chk_split_high_flag: assert property ( // see (R9)
		split && !cap_en && run && tick_hi && count[15:8] == BYTE_TOP &&
		!wr_cnt_hi |=> high_flag && count[15:8] == $past(reload[15:8]))
		else $error("high byte wrap missed in split mode");
	chk_flag_sticky: assert property ( // see (R11)
		high_flag && !wr_ctrl |=> high_flag)
		else $error("high flag cleared without software");
	chk_capture_step: assert property ( // see (R12)
		cap_en && run && tick_lo && !wr_cnt_lo && !wr_cnt_hi |=>
		count == $past(count) + 16'h0001)
		else $error("capture mode count did not step");
	chk_capture_trigger: assert property ( // see (R13)
		cap_en && !cfg[BIT_SEL_HI] && comp_rise |=>
		reload == $past(count) && high_flag)
		else $error("comparator edge did not capture");
	chk_capture_copy: assert property ( // see (R14)
		cap_event |=> reload == $past(count) && high_flag)
		else $error("capture did not copy count and flag");
	chk_ctrl_write: assert property ( // see (R15)
		wr_ctrl |=> cfg == $past(w_byte[CFG_W-1:0]))
		else $error("control write not stored");

	cov_wide_wrap: cover property (!split && hi_wrap);
	cov_split_low: cover property (split && lo_wrap);
	cov_capture: cover property (cap_event ##1 timer_irq);
endmodule
`default_nettype wire

// [design/arct_pkg.sv]
`default_nettype none
package arct_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	typedef struct packed {
		logic awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic wvalid;
		logic [DATA_W-1:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [ADDR_W-1:0] araddr;
		logic rready;
	} arct_axil_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [DATA_W-1:0] rdata;
		logic [1:0] rresp;
	} arct_axil_rsp_t;

	// register byte addresses
	localparam logic [ADDR_W-1:0] OFF_TIMER_CONTROL = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_COUNT_LOW = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_COUNT_HIGH = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_RELOAD_LOW = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_RELOAD_HIGH = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_CLOCK_CONTROL = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 8'h18;

	// timer_control_reg fields
	localparam int BIT_HIGH_FLAG = 7;
	localparam int BIT_LOW_FLAG = 6;
	localparam int CFG_W = 6;
	localparam int BIT_LOW_IRQ_EN = 5;
	localparam int BIT_CAPTURE_EN = 4;
	localparam int BIT_SPLIT = 3;
	localparam int BIT_RUN = 2;
	localparam int BIT_SEL_HI = 1;
	localparam int BIT_SEL_LO = 0;
	// clock_control_reg and interrupt_enable_reg fields
	localparam int BIT_LOW_CLK_SEL = 0;
	localparam int BIT_HIGH_CLK_SEL = 1;
	localparam int BIT_TIMER_IRQ_EN = 0;

	localparam logic [CFG_W-1:0] CFG_RESET = 6'h00;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] RELOAD_RESET = 16'h0000;
	localparam logic [15:0] COUNT_TOP = 16'hFFFF;
	localparam logic [7:0] BYTE_TOP = 8'hFF;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	localparam int SYSTEM_CLOCK_DIVIDE = 12;
	localparam int EXT_DIVIDE = 8;

	typedef enum logic [1:0] {
		SRC_DIV12_A = 2'b00,
		SRC_EXT_DIV8 = 2'b01,
		SRC_DIV12_B = 2'b10,
		SRC_COMPARATOR = 2'b11
	} arct_src_t;
endpackage
`default_nettype wire

// [design/arct_edge_sync.sv]
`timescale 1ns/10ps
`default_nettype none
module arct_edge_sync (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic async_in,
	output logic rise
);
	logic [2:0] stages;
	logic level;

	// stage 0 feeds only stage 1; edge counts once stages 1 and 2 agree
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			stages <= 3'h0;
		end else begin
			stages <= {stages[1:0], async_in};
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			level <= 1'b0;
			rise <= 1'b0;
		end else begin
			// level resets to the pin's idle low, so no false edge
			if (stages[1] == stages[2]) begin
				level <= stages[2];
			end
			rise <= (stages[1] == stages[2]) && stages[2] && !level;
		end
	end
endmodule
`default_nettype wire

// [tb/autoreload_capture_timer_bench.sv]
`timescale 1ns/10ps
`default_nettype none
module autoreload_capture_timer_bench;
	import arct_pkg::*;
	logic sys_clk;
	logic rst_n;
	logic ext_osc_in;
	logic comparator_in;
	logic timer_irq;
	arct_axil_req_t req;
	arct_axil_rsp_t rsp;
	logic [31:0] d;
	logic [1:0] r;
	int bad_count;
	int n_tests;
	int i;
	logic [7:0] ta [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14,
		8'h18, 8'h1C};
	logic [31:0] tw [8] = '{32'hE3, 32'h5A, 32'hA5, 32'h3C, 32'hC3,
		32'hFF, 32'h00, 32'h11};
	logic [31:0] te [8] = '{32'hE3, 32'h5A, 32'hA5, 32'h3C, 32'hC3,
		32'h03, 32'h00, 32'h00};
	logic [1:0] tr [8] = '{RESP_OKAY, RESP_OKAY, RESP_OKAY, RESP_OKAY,
		RESP_OKAY, RESP_OKAY, RESP_OKAY, RESP_SLVERR};
	// expected count after one clock-source pass, per external select
	int lo_t [4] = '{13, 2, 13, 5};
	int hi_t [4] = '{17, 2, 17, 5};

	arct_timer #(.PRESCALE_DIV(12), .EXT_DIV(8)) dut_u (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.axil_req(req),
		.axil_rsp(rsp),
		.ext_osc_in(ext_osc_in),
		.comparator_in(comparator_in),
		.timer_irq(timer_irq)
	);

	initial begin
		sys_clk = 1'h0;
		forever #2 sys_clk = ~sys_clk;
	end

	task automatic complete_run;
		$display("tests %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch at %0t: got %h exp %h", $time, g, e);
		end
	endtask

	task automatic chk_rng(input logic [31:0] g, input int lo, input int hi);
		n_tests++;
		if ((g >= lo && g <= hi) !== 1'h1) begin
			bad_count++;
			$display("mismatch at %0t: got %h exp %h..%h", $time, g, lo, hi);
		end
	endtask

	// answer latency is left to the slave; the watchdog ends a hang
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge sys_clk);
		req.awvalid <= 1'h1;
		req.awaddr <= a;
		req.wvalid <= 1'h1;
		req.wdata <= v;
		req.bready <= 1'h1;
		do begin
			@(posedge sys_clk);
			if (rsp.awready) req.awvalid <= 1'h0;
			if (rsp.wready) req.wvalid <= 1'h0;
		end while (!rsp.bvalid);
		r = rsp.bresp;
		req.bready <= 1'h0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge sys_clk);
		req.arvalid <= 1'h1;
		req.araddr <= a;
		req.rready <= 1'h1;
		do begin
			@(posedge sys_clk);
			if (rsp.arready) req.arvalid <= 1'h0;
		end while (!rsp.rvalid);
		d = rsp.rdata;
		r = rsp.rresp;
		req.rready <= 1'h0;
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m);
		rd(a);
		chk_val(d & m, e);
	endtask

	task automatic rr(input logic [7:0] a, input int lo, input int hi);
		rd(a);
		chk_rng(d, lo, hi);
	endtask

	task automatic irq_is(input logic e);
		repeat (3) @(posedge sys_clk);
		chk_val({31'h0, timer_irq}, {31'h0, e});
	endtask

	// slow pin edges: eight system cycles per period
	task automatic pulse(input bit cmp, input int n);
		repeat (n) begin
			repeat (4) @(posedge sys_clk);
			if (cmp) comparator_in <= 1'h1;
			else ext_osc_in <= 1'h1;
			repeat (4) @(posedge sys_clk);
			if (cmp) comparator_in <= 1'h0;
			else ext_osc_in <= 1'h0;
		end
	endtask

	initial begin
		repeat (20000) @(posedge sys_clk);
		bad_count++;
		complete_run();
	end

	initial begin
		rst_n = 1'h0;
		ext_osc_in = 1'h0;
		comparator_in = 1'h0;
		req = '0;
		req.wstrb = 4'hF;
		bad_count = 0;
		n_tests = 0;
		repeat (5) @(posedge sys_clk);
		chk_val({31'h0, rsp.awready}, 32'h0);
		rst_n <= 1'h1;
		@(posedge sys_clk);
		@(negedge sys_clk);
		chk_val({31'h0, rsp.awready}, 32'h1);
		chk_val({31'h0, timer_irq}, 32'h0);
		for (i = 0; i < 8; i++) begin
			rd(ta[i]);
			chk_val(d, 32'h0);
			chk_val({30'h0, r}, {30'h0, tr[i]});
			wr(ta[i], tw[i]);
			chk_val({30'h0, r}, {30'h0, tr[i]});
			rd(ta[i]);
			chk_val(d, te[i]);
		end
		// a write without lane 0 is answered but changes nothing
		req.wstrb <= 4'hE;
		wr(OFF_RELOAD_LOW, 32'hAA);
		req.wstrb <= 4'hF;
		chk_val({30'h0, r}, {30'h0, RESP_OKAY});
		rc(OFF_RELOAD_LOW, 32'h3C, 32'hFF);
		wr(OFF_TIMER_CONTROL, 32'h00);
		// 16-bit wrap reloads 0x1234 and raises the high flag
		wr(OFF_CLOCK_CONTROL, 32'h01);
		wr(OFF_RELOAD_LOW, 32'h34);
		wr(OFF_RELOAD_HIGH, 32'h12);
		wr(OFF_COUNT_LOW, 32'hF0);
		wr(OFF_COUNT_HIGH, 32'hFF);
		wr(OFF_IRQ_ENABLE, 32'h01);
		wr(OFF_TIMER_CONTROL, 32'h04);
		repeat (40) @(posedge sys_clk);
		rc(OFF_COUNT_HIGH, 32'h12, 32'hFF);
		rr(OFF_COUNT_LOW, 8'h34, 8'h90);
		rc(OFF_TIMER_CONTROL, 32'h80, 32'h80);
		irq_is(1'h1);
		repeat (30) @(posedge sys_clk);
		rc(OFF_TIMER_CONTROL, 32'h80, 32'h80);
		wr(OFF_TIMER_CONTROL, 32'h00);
		irq_is(1'h0);
		// low-byte wrap interrupts only with the low enable set
		wr(OFF_RELOAD_LOW, 32'h00);
		wr(OFF_RELOAD_HIGH, 32'h00);
		wr(OFF_COUNT_HIGH, 32'h00);
		wr(OFF_COUNT_LOW, 32'hF0);
		wr(OFF_TIMER_CONTROL, 32'h24);
		repeat (40) @(posedge sys_clk);
		rc(OFF_TIMER_CONTROL, 32'h40, 32'hC0);
		irq_is(1'h1);
		wr(OFF_TIMER_CONTROL, 32'h40);
		irq_is(1'h0);
		// split: low byte free-running, high byte gated by run
		wr(OFF_CLOCK_CONTROL, 32'h03);
		wr(OFF_RELOAD_LOW, 32'h40);
		wr(OFF_RELOAD_HIGH, 32'h80);
		wr(OFF_COUNT_LOW, 32'hF0);
		wr(OFF_COUNT_HIGH, 32'hF0);
		wr(OFF_TIMER_CONTROL, 32'h08);
		repeat (40) @(posedge sys_clk);
		rc(OFF_COUNT_HIGH, 32'hF0, 32'hFF);
		rr(OFF_COUNT_LOW, 8'h40, 8'h9F);
		rc(OFF_TIMER_CONTROL, 32'h40, 32'hC0);
		irq_is(1'h0);
		wr(OFF_TIMER_CONTROL, 32'h0C);
		repeat (40) @(posedge sys_clk);
		rc(OFF_TIMER_CONTROL, 32'h80, 32'h80);
		rr(OFF_COUNT_HIGH, 8'h80, 8'hBF);
		irq_is(1'h1);
		wr(OFF_TIMER_CONTROL, 32'h68);
		irq_is(1'h1);
		wr(OFF_TIMER_CONTROL, 32'h00);
		// each external select with both bytes on the selected source
		wr(OFF_CLOCK_CONTROL, 32'h00);
		for (i = 0; i < 4; i++) begin
			wr(OFF_COUNT_LOW, 32'h00);
			wr(OFF_COUNT_HIGH, 32'h00);
			wr(OFF_TIMER_CONTROL, 32'h0C | i);
			pulse(1'h0, 16);
			pulse(1'h1, 5);
			repeat (10) @(posedge sys_clk);
			wr(OFF_TIMER_CONTROL, i);
			rr(OFF_COUNT_LOW, lo_t[i], hi_t[i]);
			rr(OFF_COUNT_HIGH, lo_t[i], hi_t[i]);
		end
		// capture on comparator edge, then on eight oscillator cycles
		wr(OFF_CLOCK_CONTROL, 32'h01);
		wr(OFF_COUNT_LOW, 32'h00);
		wr(OFF_COUNT_HIGH, 32'h00);
		wr(OFF_RELOAD_LOW, 32'h00);
		wr(OFF_TIMER_CONTROL, 32'h14);
		repeat (20) @(posedge sys_clk);
		pulse(1'h0, 8);
		repeat (10) @(posedge sys_clk);
		rc(OFF_TIMER_CONTROL, 32'h00, 32'h80);
		pulse(1'h1, 1);
		repeat (10) @(posedge sys_clk);
		rc(OFF_TIMER_CONTROL, 32'h80, 32'h80);
		rr(OFF_RELOAD_LOW, 8'h30, 8'hFF);
		irq_is(1'h1);
		wr(OFF_TIMER_CONTROL, 32'h16);
		pulse(1'h0, 7);
		pulse(1'h1, 1);
		repeat (10) @(posedge sys_clk);
		rc(OFF_TIMER_CONTROL, 32'h00, 32'h80);
		pulse(1'h0, 1);
		repeat (10) @(posedge sys_clk);
		rc(OFF_TIMER_CONTROL, 32'h80, 32'h80);
		rr(OFF_RELOAD_HIGH, 8'h00, 8'h02);
		// reset in mid-run drops the interrupt and returns the control and low reload registers to zero
		rst_n <= 1'h0;
		repeat (2) @(posedge sys_clk);
		chk_val({31'h0, timer_irq}, 32'h0);
		rst_n <= 1'h1;
		rc(OFF_TIMER_CONTROL, 32'h00, 32'hFF);
		rc(OFF_RELOAD_LOW, 32'h00, 32'hFF);
		complete_run();
	end
endmodule
`default_nettype wire
